// >>> pkg/stm_pkg.sv
// package for the 16-bit standard timer: offsets, fields, types
package stm_pkg;

  // --------------------------------------------------------------------
  // register offsets (byte addresses on the plain register port)
  // --------------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL0   = 4'h0;
  localparam logic [3:0] OFF_CTRL1   = 4'h1;
  localparam logic [3:0] OFF_CNT_LO  = 4'h2;
  localparam logic [3:0] OFF_CNT_HI  = 4'h3;
  localparam logic [3:0] OFF_CMPA_LO = 4'h4;
  localparam logic [3:0] OFF_CMPA_HI = 4'h5;
  localparam logic [3:0] OFF_PERIOD  = 4'h6;
  localparam logic [3:0] OFF_IRQ_ST  = 4'h7;
  localparam logic [3:0] OFF_IRQ_MSK = 4'h8;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int PAUSE_BIT  = 7;
  localparam int CKSEL_LSB  = 4;
  localparam int ENABLE_BIT = 3;
  localparam int MODE_LSB   = 6;
  localparam int PINFN_LSB  = 4;
  localparam int INIT_BIT   = 3;
  localparam int POL_BIT    = 2;
  localparam int DPX_BIT    = 1;
  localparam int CCLR_BIT   = 0;
  localparam int IRQ_A_BIT  = 0;
  localparam int IRQ_P_BIT  = 1;

  // --------------------------------------------------------------------
  // reset values and counts
  // --------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [7:0]  CTRL0_RDMASK = 8'hf8;
  localparam logic [5:0]  DIV_RST      = 6'h00;

  // clock select codes
  localparam logic [2:0] CK_SYS4   = 3'h0;
  localparam logic [2:0] CK_SYS    = 3'h1;
  localparam logic [2:0] CK_HI16   = 3'h2;
  localparam logic [2:0] CK_HI64   = 3'h3;
  localparam logic [2:0] CK_SUB0   = 3'h4;
  localparam logic [2:0] CK_SUB1   = 3'h5;
  localparam logic [2:0] CK_EXT_RI = 3'h6;
  localparam logic [2:0] CK_EXT_FA = 3'h7;

  // mode select codes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_UND = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;

  // pin function codes
  localparam logic [1:0] FN_KEEP  = 2'h0;
  localparam logic [1:0] FN_LOW   = 2'h1;
  localparam logic [1:0] FN_HIGH  = 2'h2;
  localparam logic [1:0] FN_TOG   = 2'h3;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    SP_IDLE,
    SP_RUN,
    SP_DONE
  } stm_sp_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } stm_bus_t;

  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [15:0] cnt;
    logic [15:0] cmpa;
    logic [7:0]  period;
    logic [7:0]  buf8;
    logic [1:0]  irq_st;
    logic [1:0]  irq_msk;
    logic [7:0]  rdata;
    logic        pin;
    logic        irq;
    logic        irq_a;
    logic        irq_p;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_d;
    logic [5:0]  div;
    stm_sp_t     sp;
  } stm_state_t;

endpackage : stm_pkg

// >>> hdl/stm_timer.sv
// 16-bit standard timer: counter, two comparators, output pin, registers
//
// Operation
// [RULE1] sixteen-bit counter counting up on selected clock
// [RULE2] comparator P matches period against counter high byte
// [RULE3] comparator A matches all sixteen counter bits
// [RULE4] separate interrupt requests for A and P
// [RULE5] overflow or selected match clears the counter
// [RULE6] enable rising edge also clears the counter
// [RULE7] pause bit holds count, resume from held
// [RULE8] clock select picks divided, sub or pin edge
// [RULE9] pin is trigger in single pulse mode
// [RULE10] compare match drives pin high, low, toggle
// [RULE11] pwm appears on the same output pin
// [RULE12] low byte write buffered, copied on high write
// [RULE13] high read latches low byte into buffer
// [RULE14] counter read only, compare pair, period byte
// [RULE15] enable runs counter, rise zeroes, fall keeps
// [RULE16] mode field selects compare, pwm, timer mode
// [RULE17] period zero gives 65536, else N times 256
// [RULE18] pin synchronised, one count per selected edge
module stm_timer (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       hi_tick_i,
  input  wire logic       sub_tick_i,
  input  wire logic       ext_clock_pin_i,
  output logic      [7:0] reg_rdata_o,
  output logic            timer_output_pin_o,
  output logic            irq_a_o,
  output logic            irq_p_o,
  output logic            irq_o
);

  // --------------------------------------------------------------------
  // state and bus bundle
  // --------------------------------------------------------------------
  stm_pkg::stm_state_t state_ff;
  stm_pkg::stm_state_t nxt_state;
  stm_pkg::stm_bus_t   bus;

  assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i,
                 wr: reg_wr_i, rd: reg_rd_i};

  // --------------------------------------------------------------------
  // outputs straight from flip-flops
  // --------------------------------------------------------------------
  assign reg_rdata_o        = state_ff.rdata;
  assign timer_output_pin_o = state_ff.pin;
  assign irq_a_o            = state_ff.irq_a;
  assign irq_p_o            = state_ff.irq_p;
  assign irq_o              = state_ff.irq;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  // the high-speed and sub clocks arrive as one-cycle ticks from the clock
  // unit, so the counter stays in the system domain and needs no crossing
  always_comb begin
    logic [2:0]  cksel;
    logic [1:0]  mode;
    logic [1:0]  pinfn;
    logic        en_now;
    logic        en_new;
    logic        tick;
    logic        match_a;
    logic        match_p;
    logic        ovf;
    logic        clr;
    logic        init_lvl;
    logic        raw;
    logic        ext_rise;
    logic        ext_fall;
    logic [1:0]  ev;
    logic [15:0] duty_v;
    logic [15:0] per_v;
    nxt_state = state_ff;
    tick     = 1'b0;
    match_a  = 1'b0;
    match_p  = 1'b0;
    ovf      = 1'b0;
    clr      = 1'b0;
    ext_rise = 1'b0;
    ext_fall = 1'b0;
    duty_v   = 16'h0000;
    per_v    = 16'h0000;
    cksel    = state_ff.ctrl0[stm_pkg::CKSEL_LSB +: 3];
    mode     = state_ff.ctrl1[stm_pkg::MODE_LSB +: 2];
    pinfn    = state_ff.ctrl1[stm_pkg::PINFN_LSB +: 2];
    en_now   = state_ff.ctrl0[stm_pkg::ENABLE_BIT];
    en_new   = en_now;
    init_lvl = state_ff.ctrl1[stm_pkg::INIT_BIT];
    raw      = 1'b0;
    ev       = 2'b00;

    // two-stage synchroniser, edge detect on the second stage only
    nxt_state.ext_s1 = ext_clock_pin_i;
    nxt_state.ext_s2 = state_ff.ext_s1;
    nxt_state.ext_d  = state_ff.ext_s2;
    ext_rise = state_ff.ext_s2 & ~state_ff.ext_d;  // RULE18
    ext_fall = ~state_ff.ext_s2 & state_ff.ext_d;  // RULE18

    // prescaler runs freely except under the hi selects, so the divided ticks are evenly spaced
    nxt_state.div = state_ff.div + 6'h01;
    case (cksel)
      stm_pkg::CK_SYS4:   tick = (state_ff.div[1:0] == 2'h3);  // RULE8
      stm_pkg::CK_SYS:    tick = 1'b1;                         // RULE8
      stm_pkg::CK_HI16:   tick = hi_tick_i
                                 & (state_ff.div[3:0] == 4'hf); // RULE8
      stm_pkg::CK_HI64:   tick = hi_tick_i
                                 & (state_ff.div == 6'h3f);     // RULE8
      stm_pkg::CK_SUB0,
      stm_pkg::CK_SUB1:   tick = sub_tick_i;                   // RULE8
      stm_pkg::CK_EXT_RI: tick = ext_rise;                     // RULE18
      stm_pkg::CK_EXT_FA: tick = ext_fall;                     // RULE18
      default:            tick = 1'b0;
    endcase
    // hi ticks only advance the divider when present
    if (cksel == stm_pkg::CK_HI16 || cksel == stm_pkg::CK_HI64) begin
      nxt_state.div = hi_tick_i ? state_ff.div + 6'h01 : state_ff.div;
    end

    // single pulse mode uses the pin as trigger, not as clock
    if (mode == stm_pkg::MODE_PWM && pinfn == stm_pkg::FN_TOG) begin
      tick = (cksel == stm_pkg::CK_EXT_RI || cksel == stm_pkg::CK_EXT_FA)
             ? 1'b1 : tick;
    end

    // comparators
    match_a = (state_ff.cnt == state_ff.cmpa);               // RULE3
    // p looks at the high byte the next tick reaches, so a period of n
    // spans exactly n x 256 ticks instead of one block more
    match_p = (state_ff.cnt[15:8] + 8'h01 == state_ff.period); // RULE2
    ovf     = (state_ff.cnt == 16'hffff);
    // a match counts only on the tick that would leave the matched value
    if (state_ff.ctrl1[stm_pkg::CCLR_BIT] &&
        mode != stm_pkg::MODE_PWM) begin
      clr = match_a;                                         // RULE5
    end else if (state_ff.period == 8'h00) begin
      clr = ovf;                                             // RULE17
    end else begin
      clr = match_p & (state_ff.cnt[7:0] == 8'hff);          // RULE17
    end

    // counting: enable on, pause off
    if (en_now && !state_ff.ctrl0[stm_pkg::PAUSE_BIT] && tick &&
        state_ff.sp != stm_pkg::SP_IDLE) begin               // RULE7
      if (clr) begin
        nxt_state.cnt = stm_pkg::CNT_RST;                    // RULE5
      end else begin
        nxt_state.cnt = state_ff.cnt + 16'h0001;             // RULE1
      end
      ev[stm_pkg::IRQ_A_BIT] = (state_ff.cnt + 16'h0001 == state_ff.cmpa);
      ev[stm_pkg::IRQ_P_BIT] = clr & ~state_ff.ctrl1[stm_pkg::CCLR_BIT];
    end

    // single pulse sequencing; other modes stay running
    case (state_ff.sp)
      stm_pkg::SP_IDLE: begin
        if (!(mode == stm_pkg::MODE_PWM && pinfn == stm_pkg::FN_TOG)) begin
          nxt_state.sp = stm_pkg::SP_RUN;
        end else if ((cksel == stm_pkg::CK_EXT_FA) ? ext_fall
                                                   : ext_rise) begin
          nxt_state.sp = stm_pkg::SP_RUN;                    // RULE9
        end
      end
      stm_pkg::SP_RUN: begin
        if (mode == stm_pkg::MODE_PWM && pinfn == stm_pkg::FN_TOG &&
            ev[stm_pkg::IRQ_A_BIT]) begin
          nxt_state.sp = stm_pkg::SP_DONE;
        end
      end
      stm_pkg::SP_DONE: nxt_state.sp = stm_pkg::SP_DONE;
      default:          nxt_state.sp = stm_pkg::SP_IDLE;
    endcase

    // output pin per mode
    duty_v = state_ff.ctrl1[stm_pkg::DPX_BIT] ? {state_ff.period, 8'h00}
                                              : state_ff.cmpa;
    per_v  = state_ff.ctrl1[stm_pkg::DPX_BIT] ? state_ff.cmpa
                                              : {state_ff.period, 8'h00};
    case (mode)
      stm_pkg::MODE_CMP: begin
        raw = state_ff.pin ^ state_ff.ctrl1[stm_pkg::POL_BIT];
        if (ev[stm_pkg::IRQ_A_BIT]) begin
          case (pinfn)
            stm_pkg::FN_LOW:  raw = 1'b0;                    // RULE10
            stm_pkg::FN_HIGH: raw = 1'b1;                    // RULE10
            stm_pkg::FN_TOG:  raw = ~raw;                    // RULE10
            default:          raw = raw;
          endcase
        end
      end
      stm_pkg::MODE_PWM: begin
        case (pinfn)
          stm_pkg::FN_KEEP: raw = ~init_lvl;
          stm_pkg::FN_LOW:  raw = init_lvl;
          stm_pkg::FN_HIGH: raw = (state_ff.cnt < duty_v &&
                                   (per_v == 16'h0000 ||
                                    state_ff.cnt < per_v))
                                  ? init_lvl : ~init_lvl;    // RULE11
          default:          raw = (state_ff.sp == stm_pkg::SP_RUN)
                                  ? init_lvl : ~init_lvl;    // RULE9
        endcase
      end
      default: raw = state_ff.pin ^ state_ff.ctrl1[stm_pkg::POL_BIT];
    endcase
    nxt_state.pin = raw ^ state_ff.ctrl1[stm_pkg::POL_BIT];

    // interrupt strobes and sticky status; set wins over clear
    nxt_state.irq_a = ev[stm_pkg::IRQ_A_BIT];                // RULE4
    nxt_state.irq_p = ev[stm_pkg::IRQ_P_BIT];                // RULE4
    nxt_state.irq_st = state_ff.irq_st;
    if (bus.wr && bus.addr == stm_pkg::OFF_IRQ_ST) begin
      nxt_state.irq_st = state_ff.irq_st & ~bus.wdata[1:0];
    end
    nxt_state.irq_st = nxt_state.irq_st | ev;

    // register writes; no path writes the counter directly
    if (bus.wr) begin
      case (bus.addr)
        stm_pkg::OFF_CTRL0: begin
          nxt_state.ctrl0 = bus.wdata & stm_pkg::CTRL0_RDMASK;
          en_new = bus.wdata[stm_pkg::ENABLE_BIT];
        end
        stm_pkg::OFF_CTRL1:   nxt_state.ctrl1 = bus.wdata;
        stm_pkg::OFF_CMPA_LO: nxt_state.buf8 = bus.wdata;      // RULE12
        stm_pkg::OFF_CMPA_HI: nxt_state.cmpa = {bus.wdata,
                                                state_ff.buf8}; // RULE12
        stm_pkg::OFF_PERIOD:  nxt_state.period = bus.wdata;    // RULE14
        stm_pkg::OFF_IRQ_MSK: nxt_state.irq_msk = bus.wdata[1:0];
        default: ;
      endcase
    end

    // enable rise zeroes the count and, outside timer mode, rearms the pin
    if (en_new && !en_now) begin
      nxt_state.cnt = stm_pkg::CNT_RST;                      // RULE6
      nxt_state.sp  = stm_pkg::SP_IDLE;                      // RULE15
      if (mode != stm_pkg::MODE_TMR) begin
        nxt_state.pin = init_lvl ^ state_ff.ctrl1[stm_pkg::POL_BIT];
      end
    end

    // register reads, data in the following cycle
    nxt_state.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        stm_pkg::OFF_CTRL0:   nxt_state.rdata = state_ff.ctrl0;
        stm_pkg::OFF_CTRL1:   nxt_state.rdata = state_ff.ctrl1;
        stm_pkg::OFF_CNT_HI: begin
          nxt_state.rdata = state_ff.cnt[15:8];              // RULE13
          nxt_state.buf8  = state_ff.cnt[7:0];               // RULE13
        end
        stm_pkg::OFF_CMPA_HI: begin
          nxt_state.rdata = state_ff.cmpa[15:8];             // RULE13
          nxt_state.buf8  = state_ff.cmpa[7:0];              // RULE13
        end
        stm_pkg::OFF_CNT_LO,
        stm_pkg::OFF_CMPA_LO: nxt_state.rdata = state_ff.buf8; // RULE13
        stm_pkg::OFF_PERIOD:  nxt_state.rdata = state_ff.period;
        stm_pkg::OFF_IRQ_ST:  nxt_state.rdata = {6'h00, state_ff.irq_st};
        stm_pkg::OFF_IRQ_MSK: nxt_state.rdata = {6'h00, state_ff.irq_msk};
        default:              nxt_state.rdata = 8'h00;
      endcase
    end

    nxt_state.irq = |(nxt_state.irq_st & nxt_state.irq_msk);
    if (mode == stm_pkg::MODE_UND) begin
      nxt_state.sp = stm_pkg::SP_RUN;                        // RULE16
    end
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= '{ctrl0: stm_pkg::CTRL_RST, ctrl1: stm_pkg::CTRL_RST,
                    cnt: stm_pkg::CNT_RST, cmpa: stm_pkg::CNT_RST,
                    period: stm_pkg::CTRL_RST, buf8: stm_pkg::CTRL_RST,
                    irq_st: 2'h0, irq_msk: 2'h0,
                    rdata: stm_pkg::CTRL_RST, pin: 1'b0, irq: 1'b0,
                    irq_a: 1'b0, irq_p: 1'b0, ext_s1: 1'b0,
                    ext_s2: 1'b0, ext_d: 1'b0, div: stm_pkg::DIV_RST,
                    sp: stm_pkg::SP_IDLE};
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule : stm_timer

// >>> tb/stm_timer_assertions.sv
// checker for the standard timer, watching its ports only
module stm_checker (
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       timer_output_pin_o,
  input wire logic       irq_a_o,
  input wire logic       irq_p_o,
  input wire logic       irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  // --------------------------------------------------------------
  // mirrors of written registers
  // --------------------------------------------------------------
  logic [7:0] c0_ff;
  logic [7:0] c1_ff;
  logic [7:0] per_ff;
  logic [1:0] msk_ff;
  logic [3:0] idle_ff;
  logic       run;

  assign run = c0_ff[stm_pkg::ENABLE_BIT] && !c0_ff[stm_pkg::PAUSE_BIT];

  // the register file is hidden, so writes are mirrored here
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      c0_ff  <= stm_pkg::CTRL_RST;
      c1_ff  <= stm_pkg::CTRL_RST;
      per_ff <= 8'h00;
      msk_ff <= 2'h0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        stm_pkg::OFF_CTRL0:   c0_ff  <= reg_wdata_i;
        stm_pkg::OFF_CTRL1:   c1_ff  <= reg_wdata_i;
        stm_pkg::OFF_PERIOD:  per_ff <= reg_wdata_i;
        stm_pkg::OFF_IRQ_MSK: msk_ff <= reg_wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // cycles stopped or paused; saturates so it never wraps to zero
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_ff <= 4'h0;
    end else if (run) begin
      idle_ff <= 4'h0;
    end else if (idle_ff != 4'hf) begin
      idle_ff <= idle_ff + 4'h1;
    end
  end

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  unmapped_zero_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) > 4'h8 |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  ctrl0_read_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == stm_pkg::OFF_CTRL0
    |-> reg_rdata_o == (c0_ff & stm_pkg::CTRL0_RDMASK))
    else $error("control 0 read mismatch");
  ctrl1_read_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == stm_pkg::OFF_CTRL1
    |-> reg_rdata_o == c1_ff)
    else $error("control 1 read mismatch");
  period_read_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == stm_pkg::OFF_PERIOD
    |-> reg_rdata_o == per_ff)
    else $error("period read mismatch");
  irqa_pulse_a: assert property (irq_a_o |=> !irq_a_o)
    else $error("A event longer than a cycle");
  quiet_stop_a: assert property (
    idle_ff > 4'h5 |-> !irq_a_o && !irq_p_o)
    else $error("event while stopped or paused");
  irq_raise_a: assert property (
    irq_a_o && msk_ff[0] || irq_p_o && msk_ff[1] |-> ##[1:2] irq_o)
    else $error("unmasked event gave no interrupt");
  irq_mask_a: assert property (
    reg_wr_i && reg_addr_i == stm_pkg::OFF_IRQ_MSK
    && reg_wdata_i[1:0] == 2'h0 |-> ##2 !irq_o)
    else $error("interrupt high with all masked");
  pin_cause_a: assert property (
    c1_ff[7:6] == stm_pkg::MODE_CMP && $changed(timer_output_pin_o)
    && !$past(reg_wr_i) && !$past(reg_wr_i, 2)
    |-> irq_a_o || $past(irq_a_o) || $past(irq_a_o, 2))
    else $error("pin moved without A match");
endmodule : stm_checker

bind stm_timer stm_checker u_stm_checker (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .timer_output_pin_o(timer_output_pin_o),
  .irq_a_o(irq_a_o), .irq_p_o(irq_p_o), .irq_o(irq_o)
);

// >>> tb/stm_event_src.sv
// event source driving the timer's external clock pin
module stm_event_src (
  input  wire logic mclk_i,
  output logic      ext_clock_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial ext_clock_pin_o = 1'b0;

  // pulses of 4 high and 4 low cycles; idles low so no stray edge
  // reaches the counter between bursts
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      ext_clock_pin_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      ext_clock_pin_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
    end
  endtask : pulses
endmodule : stm_event_src

// >>> tb/stm_timer_bench.sv
// self-checking bench for the standard timer
module stm_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] C0 = stm_pkg::OFF_CTRL0;
  localparam logic [3:0] C1 = stm_pkg::OFF_CTRL1;
  localparam logic [3:0] CH = stm_pkg::OFF_CNT_HI;
  localparam logic [3:0] AL = stm_pkg::OFF_CMPA_LO;
  localparam logic [3:0] AH = stm_pkg::OFF_CMPA_HI;
  localparam logic [3:0] ST = stm_pkg::OFF_IRQ_ST;
  localparam logic [3:0] MK = stm_pkg::OFF_IRQ_MSK;
  logic        mclk_i, sys_rst_i, wr, rd, hi_tick, sub_tick, ext_pin;
  logic        pin, irq_a, irq_p, irq;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [2:0]  tk;
  logic [15:0] v1, v2;
  int          n;
  int          n_errors = 0;
  int          n_checks = 0;

  stm_timer u_stm_timer (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .hi_tick_i(hi_tick), .sub_tick_i(sub_tick), .ext_clock_pin_i(ext_pin),
    .reg_rdata_o(rdata), .timer_output_pin_o(pin), .irq_a_o(irq_a),
    .irq_p_o(irq_p), .irq_o(irq)
  );
  stm_event_src u_stm_event_src (.mclk_i(mclk_i), .ext_clock_pin_o(ext_pin));

  // --------------------------------------------------------------
  // clock, ticks and bus tasks
  // --------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // high and sub clock ticks at the same rate, one every 8 clocks, in different phases
  always @(posedge mclk_i) begin
    tk       <= tk + 3'h1;
    hi_tick  <= tk == 3'h0;
    sub_tick <= tk == 3'h5;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic cb(input logic g, input logic e);
    chk({15'h0, g}, {15'h0, e});
  endtask : cb

  task automatic wb(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask : wb

  // read data stand only in the cycle after the strobe
  task automatic rb(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rb

  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rb(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rc

  // high byte first, so the low byte is latched with it
  task automatic r16(input logic [3:0] h, output logic [15:0] v);
    rb(h, v[15:8]);
    rb(h - 4'h1, v[7:0]);
  endtask : r16

  // cycles until the next A or P event, bounded against a hang
  task automatic wev(input bit p, output int c);
    c = 0;
    do begin
      @(posedge mclk_i);
      #1 c++;
    end while ((p ? irq_p : irq_a) !== 1'b1 && c < 5000);
  endtask : wev

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // the tests take some 4000 cycles; this cuts a hang at 20000
  initial begin
    #800000;
    n_errors++;
    print_verdict();
  end

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    {wr, rd, addr, wdata, tk, hi_tick, sub_tick} = '0;
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    // all registers reset to zero; offset f is unmapped
    for (int i = 0; i < 10; i++) begin
      rc((i == 9) ? 4'hf : 4'(i), 8'h00);
    end
    // every clock select and mode code reads back
    for (int i = 0; i < 8; i++) begin
      wb(C0, {i[0], i[2:0], 4'h7});
      rc(C0, {i[0], i[2:0], 4'h0});
      wb(C1, {i[1:0], 6'h12});
      rc(C1, {i[1:0], 6'h12});
    end
    // low byte waits in the buffer until the high byte is written or read
    wb(AL, 8'h34);
    wb(AH, 8'h12);
    r16(AH, v1);
    chk(v1, 16'h1234);
    wb(AL, 8'h99);
    r16(AH, v1);
    chk(v1, 16'h1234);
    wb(AH, 8'h00);
    r16(AH, v1);
    chk(v1, 16'h0034);
    wb(CH - 4'h1, 8'h55);
    wb(CH, 8'h55);
    r16(CH, v1);
    chk(v1, 16'h0000);
    // pause holds, resume counts on, disable keeps the residue
    wb(C1, 8'hc0);
    wb(C0, 8'h18);
    wb(C0, 8'h98);
    r16(CH, v1);
    repeat (20) @(posedge mclk_i);
    r16(CH, v2);
    chk(v2, v1);
    wb(C0, 8'h18);
    r16(CH, v2);
    cb(v2 > v1, 1'b1);
    wb(C0, 8'h10);
    r16(CH, v1);
    repeat (20) @(posedge mclk_i);
    r16(CH, v2);
    chk(v2, v1);
    // pin edges counted from zero after enable rises
    wb(C0, 8'h68);
    u_stm_event_src.pulses(5);
    r16(CH, v1);
    chk(v1, 16'd5);
    wb(C0, 8'h00);
    wb(C0, 8'h78);
    u_stm_event_src.pulses(3);
    r16(CH, v1);
    chk(v1, 16'd3);
    // period 2 against the high byte gives 512 clocks
    wb(C0, 8'h00);
    wb(stm_pkg::OFF_PERIOD, 8'h02);
    wb(C0, 8'h18);
    wev(1'b1, n);
    wev(1'b1, n);
    chk(16'(n), 16'd512);
    rc(ST, 8'h03);
    cb(irq, 1'b0);
    wb(MK, 8'h01);
    repeat (2) @(posedge mclk_i);
    cb(irq, 1'b1);
    wb(C0, 8'h00);
    wb(ST, 8'h03);
    rc(ST, 8'h00);
    cb(irq, 1'b0);
    // system clock over four: period 1 spans 256 ticks of 4 clocks
    wb(stm_pkg::OFF_PERIOD, 8'h01);
    wb(C0, 8'h08);
    wev(1'b1, n);
    wev(1'b1, n);
    chk(16'(n), 16'd1024);
    wb(C0, 8'h00);
    wb(stm_pkg::OFF_PERIOD, 8'h02);
    wb(ST, 8'h03);
    // compare A of 0x0100 clears on A and drives the pin high
    wb(AL, 8'h00);
    wb(AH, 8'h01);
    wb(C1, 8'h21);
    wb(C0, 8'h18);
    cb(pin, 1'b0);
    wev(1'b0, n);
    wev(1'b0, n);
    chk(16'(n), 16'd257);
    repeat (2) @(posedge mclk_i);
    cb(pin, 1'b1);
    cb(irq, 1'b1);
    // single pulse: pin edge starts it, A match ends it
    wb(C0, 8'h00);
    wb(C1, 8'hb8);
    wb(C0, 8'h18);
    u_stm_event_src.pulses(1);
    cb(pin, 1'b1);
    wev(1'b0, n);
    repeat (2) @(posedge mclk_i);
    cb(pin, 1'b0);
    wb(MK, 8'h00);
    repeat (3) @(posedge mclk_i);
    cb(irq, 1'b0);
    print_verdict();
  end
endmodule : stm_timer_bench
